// [inc/lctg_regs.vh]
/*
 * register map, field positions, reset values and codes for the line
 * clamp timing generator.
 * assumes: included by bare name from the design files under src/.
 */
//
// Contract
// - With the clamp-source bit (0x18 bit 4) set, the pin sets the window.
// - Polarity bit 6 of 0x18 sets the clamp pin's active level; bit 7 is unused.
// - Internally, the window opens 0x19 pixel periods after hsync ends.
// - The window then stays open 0x1A pixel periods, closed till next line.
// - Start delay and window length are 8-bit unsigned counts, 0 to 255.
// - Each of three channels has a midscale select bit in 0x18 bits [3:1].
`ifndef LCTG_REGS_VH
`define LCTG_REGS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define LCTG_OFS_CTRL 8'h18
`define LCTG_OFS_START 8'h19
`define LCTG_OFS_LENGTH 8'h1a

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define LCTG_POL_HI 7
`define LCTG_POL_LO 6
`define LCTG_SRC_BIT 4
`define LCTG_MID_HI 3
`define LCTG_MID_LO 1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define LCTG_RST_CTRL 8'h00
`define LCTG_RST_START 8'h04
`define LCTG_RST_LENGTH 8'h28

// ------------------------------------------------------------
// two-wire port
// ------------------------------------------------------------
// device address value is arbitrary
`define LCTG_DEV_ADDR 7'h4c

`endif

// [src/lctg_window_gen.v]
/*
 * internal clamp window generator: delay then window, counted in
 * pixel periods from the trailing (falling) edge of an active-high hsync.
 * assumes: mclk is the pixel clock; hsync synchronous to it.
 */
`timescale 1ns/1ps
module lctg_window_gen #(
    parameter CW = 8
)
(
    input wire mclk,
    input wire srst,
    input wire hsync,
    input wire [CW-1:0] start_delay,
    input wire [CW-1:0] window_length,
    output reg window
);

// ------------------------------------------------------------
// states
// ------------------------------------------------------------
localparam [1:0] ST_IDLE = 2'b00;
localparam [1:0] ST_DELAY = 2'b01;
localparam [1:0] ST_ACTIVE = 2'b10;

reg [1:0] state_reg;
reg [1:0] state_next;
reg [CW-1:0] cnt_reg;
reg [CW-1:0] cnt_next;
reg hsync_reg;
wire trail;

assign trail = hsync_reg & ~hsync;

always @*
begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (trail)
    begin
        if (start_delay != {CW{1'b0}})
        begin
            state_next = ST_DELAY;
            cnt_next = start_delay - {{(CW-1){1'b0}}, 1'b1};
        end
        else if (window_length != {CW{1'b0}})
        begin
            state_next = ST_ACTIVE;
            cnt_next = window_length - {{(CW-1){1'b0}}, 1'b1};
        end
        else
        begin
            state_next = ST_IDLE;
        end
    end
    else
    begin
        case (state_reg)
            ST_DELAY:
            begin
                if (cnt_reg != {CW{1'b0}})
                begin
                    cnt_next = cnt_reg - {{(CW-1){1'b0}}, 1'b1};
                end
                else if (window_length != {CW{1'b0}})
                begin
                    state_next = ST_ACTIVE;
                    cnt_next = window_length - {{(CW-1){1'b0}}, 1'b1};
                end
                else
                begin
                    state_next = ST_IDLE;
                end
            end
            ST_ACTIVE:
            begin
                if (cnt_reg != {CW{1'b0}})
                begin
                    cnt_next = cnt_reg - {{(CW-1){1'b0}}, 1'b1};
                end
                else
                begin
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end
end

always @(posedge mclk)
begin
    if (srst)
    begin
        state_reg <= ST_IDLE;
        cnt_reg <= {CW{1'b0}};
        hsync_reg <= 1'b0;
        window <= 1'b0;
    end
    else
    begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        hsync_reg <= hsync;
        window <= (state_next == ST_ACTIVE);
    end
end

endmodule // lctg_window_gen

// [src/lctg_top.v]
/*
 * line clamp timing generator: two-wire register slave, clamp source
 * and polarity selection, per-channel midscale clamp selects.
 * assumes: scl, sda_in, hsync, clamp_pin synchronous to mclk (pixel
 * clock); sda is open drain, resolved outside.
 */
`timescale 1ns/1ps
`include "lctg_regs.vh"
module lctg_top #(
    parameter [6:0] DEV_ADDR = `LCTG_DEV_ADDR,
    parameter NCH = 3
)
(
    input wire mclk,
    input wire srst,
    input wire scl,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire hsync,
    input wire clamp_pin,
    output reg clamp_active,
    output reg [NCH-1:0] clamp_midscale,
    output reg [NCH-1:0] clamp_ground
);

// ------------------------------------------------------------
// serial port states
// ------------------------------------------------------------
localparam [2:0] SP_IDLE = 3'd0;
localparam [2:0] SP_ADDR = 3'd1;
localparam [2:0] SP_SUB = 3'd2;
localparam [2:0] SP_WR = 3'd3;
localparam [2:0] SP_RD = 3'd4;
localparam [2:0] SP_ACK = 3'd5;
localparam [2:0] SP_RACK = 3'd6;

reg [7:0] ctrl_reg;
reg [7:0] start_reg;
reg [7:0] length_reg;
reg [2:0] sp_state_reg;
reg [2:0] after_reg;
reg [2:0] bit_cnt_reg;
reg byte_done_reg;
reg [7:0] shift_reg;
reg [7:0] ptr_reg;
reg more_reg;
reg scl_reg;
reg sda_reg;
reg [7:0] rd_data;
wire scl_rise;
wire scl_fall;
wire start_ev;
wire stop_ev;
wire int_window;
wire ext_window;
wire window;

assign scl_rise = ~scl_reg & scl;
assign scl_fall = scl_reg & ~scl;
assign start_ev = scl & scl_reg & sda_reg & ~sda_in;
assign stop_ev = scl & scl_reg & ~sda_reg & sda_in;

// ------------------------------------------------------------
// register read mux
// ------------------------------------------------------------
always @*
begin
    case (ptr_reg)
        `LCTG_OFS_CTRL: rd_data = ctrl_reg;
        `LCTG_OFS_START: rd_data = start_reg;
        `LCTG_OFS_LENGTH: rd_data = length_reg;
        default: rd_data = 8'h00;
    endcase
end

// ------------------------------------------------------------
// two-wire slave
// ------------------------------------------------------------
always @(posedge mclk)
begin
    if (srst)
    begin
        sp_state_reg <= SP_IDLE;
        after_reg <= SP_IDLE;
        bit_cnt_reg <= 3'd0;
        byte_done_reg <= 1'b0;
        shift_reg <= 8'h00;
        ptr_reg <= 8'h00;
        more_reg <= 1'b0;
        scl_reg <= 1'b1;
        sda_reg <= 1'b1;
        sda_out <= 1'b0;
        sda_oe <= 1'b0;
        ctrl_reg <= `LCTG_RST_CTRL;
        start_reg <= `LCTG_RST_START;
        length_reg <= `LCTG_RST_LENGTH;
    end
    else
    begin
        scl_reg <= scl;
        sda_reg <= sda_in;
        sda_out <= 1'b0;
        if (start_ev)
        begin
            sp_state_reg <= SP_ADDR;
            bit_cnt_reg <= 3'd0;
            byte_done_reg <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (stop_ev)
        begin
            sp_state_reg <= SP_IDLE;
            sda_oe <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (sp_state_reg)
                SP_ADDR, SP_SUB, SP_WR, SP_RD:
                begin
                    if (sp_state_reg != SP_RD)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_in};
                    end
                    bit_cnt_reg <= bit_cnt_reg + 3'd1;
                    byte_done_reg <= (bit_cnt_reg == 3'd7);
                end
                SP_RACK:
                begin
                    more_reg <= ~sda_in;
                end
                default:
                begin
                    more_reg <= more_reg;
                end
            endcase
        end
        else if (scl_fall)
        begin
            case (sp_state_reg)
                SP_ADDR:
                begin
                    if (byte_done_reg && shift_reg[7:1] == DEV_ADDR)
                    begin
                        byte_done_reg <= 1'b0;
                        sda_oe <= 1'b1;
                        sp_state_reg <= SP_ACK;
                        after_reg <= shift_reg[0] ? SP_RD : SP_SUB;
                    end
                    else if (byte_done_reg)
                    begin
                        sp_state_reg <= SP_IDLE;
                    end
                end
                SP_SUB:
                begin
                    if (byte_done_reg)
                    begin
                        byte_done_reg <= 1'b0;
                        ptr_reg <= shift_reg;
                        sda_oe <= 1'b1;
                        sp_state_reg <= SP_ACK;
                        after_reg <= SP_WR;
                    end
                end
                SP_WR:
                begin
                    if (byte_done_reg)
                    begin
                        byte_done_reg <= 1'b0;
                        case (ptr_reg)
                            `LCTG_OFS_CTRL: ctrl_reg <= shift_reg;
                            `LCTG_OFS_START: start_reg <= shift_reg;
                            `LCTG_OFS_LENGTH: length_reg <= shift_reg;
                            default: ctrl_reg <= ctrl_reg;
                        endcase
                        ptr_reg <= ptr_reg + 8'h01;
                        sda_oe <= 1'b1;
                        sp_state_reg <= SP_ACK;
                        after_reg <= SP_WR;
                    end
                end
                SP_ACK:
                begin
                    if (after_reg == SP_RD)
                    begin
                        shift_reg <= rd_data;
                        sda_oe <= ~rd_data[7];
                        ptr_reg <= ptr_reg + 8'h01;
                    end
                    else
                    begin
                        sda_oe <= 1'b0;
                    end
                    bit_cnt_reg <= 3'd0;
                    sp_state_reg <= after_reg;
                end
                SP_RD:
                begin
                    if (byte_done_reg)
                    begin
                        byte_done_reg <= 1'b0;
                        sda_oe <= 1'b0;
                        sp_state_reg <= SP_RACK;
                    end
                    else
                    begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe <= ~shift_reg[6];
                    end
                end
                SP_RACK:
                begin
                    if (more_reg)
                    begin
                        shift_reg <= rd_data;
                        sda_oe <= ~rd_data[7];
                        ptr_reg <= ptr_reg + 8'h01;
                        bit_cnt_reg <= 3'd0;
                        sp_state_reg <= SP_RD;
                    end
                    else
                    begin
                        sp_state_reg <= SP_IDLE;
                    end
                end
                default:
                begin
                    sp_state_reg <= SP_IDLE;
                end
            endcase
        end
    end
end

// ------------------------------------------------------------
// clamp window sources
// ------------------------------------------------------------
lctg_window_gen #(
    .CW(8)
) u_window_gen (
    .mclk(mclk),
    .srst(srst),
    .hsync(hsync),
    .start_delay(start_reg),
    .window_length(length_reg),
    .window(int_window)
);

// polarity bit 6 set: pin active high; clear: active low
assign ext_window = ~(clamp_pin ^ ctrl_reg[`LCTG_POL_LO]);
assign window = ctrl_reg[`LCTG_SRC_BIT] ? ext_window : int_window;

// ------------------------------------------------------------
// registered clamp outputs
// ------------------------------------------------------------
always @(posedge mclk)
begin
    if (srst)
    begin
        clamp_active <= 1'b0;
    end
    else
    begin
        clamp_active <= window;
    end
end

genvar ch;
generate
    for (ch = 0; ch < NCH; ch = ch + 1)
    begin : g_chan
        always @(posedge mclk)
        begin
            if (srst)
            begin
                clamp_midscale[ch] <= 1'b0;
                clamp_ground[ch] <= 1'b0;
            end
            else
            begin
                clamp_midscale[ch] <= window
                    & ctrl_reg[`LCTG_MID_LO + ch];
                clamp_ground[ch] <= window
                    & ~ctrl_reg[`LCTG_MID_LO + ch];
            end
        end
    end
endgenerate

endmodule // lctg_top

// [verification/lctg_monitor.sv]
/*
 * port checker for lctg_top, bound to every instance.
 * assumes: one clock mclk, synchronous active-high srst.
 */
`timescale 1ns/1ps
module lctg_monitor #(
    parameter NCH = 3
)
(
    input wire mclk,
    input wire srst,
    input wire scl,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire hsync,
    input wire clamp_pin,
    input wire clamp_active,
    input wire [NCH-1:0] clamp_midscale,
    input wire [NCH-1:0] clamp_ground
);
// ----------------------------------------
// properties
// ----------------------------------------
default clocking cb @(posedge mclk);
endclocking
default disable iff (srst);
property p_rst_clamp;
    $fell(srst) |-> !clamp_active [*5];
endproperty
a_rst_clamp: assert property (p_rst_clamp)
    else $error("clamp window too early after reset");
property p_rst_out;
    $fell(srst) |-> !sda_oe && clamp_midscale == 0 && clamp_ground == 0;
endproperty
a_rst_out: assert property (p_rst_out)
    else $error("outputs not cleared by reset");
property p_sda_out;
    sda_out == 1'b0;
endproperty
a_sda_out: assert property (p_sda_out)
    else $error("sda driven high");
property p_mutex;
    (clamp_midscale & clamp_ground) == 0;
endproperty
a_mutex: assert property (p_mutex)
    else $error("channel clamps to midscale and ground at once");
property p_chan;
    (clamp_midscale | clamp_ground) == {NCH{clamp_active}};
endproperty
a_chan: assert property (p_chan)
    else $error("channel clamp does not follow window");
property p_oe_low;
    $changed(sda_oe) |-> !scl;
endproperty
a_oe_low: assert property (p_oe_low)
    else $error("sda pull changed while scl high");
property p_oe_width;
    $rose(sda_oe) |-> sda_oe [*4];
endproperty
a_oe_width: assert property (p_oe_width)
    else $error("sda pull too short");
property p_oe_hold;
    scl && sda_oe |=> sda_oe;
endproperty
a_oe_hold: assert property (p_oe_hold)
    else $error("sda pull dropped during scl high");
c_win: cover property ($rose(clamp_active));
c_ack: cover property ($rose(sda_oe));
c_mid: cover property (clamp_midscale != 0);
endmodule // lctg_monitor
bind lctg_top lctg_monitor #(.NCH(NCH)) u_mon (.mclk(mclk), .srst(srst),
    .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .hsync(hsync), .clamp_pin(clamp_pin), .clamp_active(clamp_active),
    .clamp_midscale(clamp_midscale), .clamp_ground(clamp_ground));

// [verification/lctg_video_src.sv]
/*
 * video source model: an 8-cycle active-high hsync per go pulse and
 * an external clamp pin kept out of sync time.
 * assumes: go is a one-cycle request from the bench.
 */
`timescale 1ns/1ps
module lctg_video_src
(
    input wire mclk,
    input wire go,
    input wire pin_on,
    input wire pin_pol,
    output reg hsync,
    output wire clamp_pin
);
reg [3:0] hs_cnt_reg = 4'h0;
initial hsync = 1'b0;
always @(posedge mclk)
begin
    if (go)
        hs_cnt_reg <= 4'h8;
    else if (hs_cnt_reg != 4'h0)
        hs_cnt_reg <= hs_cnt_reg - 4'h1;
    hsync <= go || hs_cnt_reg > 4'h1;
end
// pin only active outside sync, whenever pin_on is set
assign clamp_pin = (pin_on && !hsync) ? pin_pol : ~pin_pol;
endmodule // lctg_video_src

// [verification/lctg_tb.sv]
/*
 * testbench for lctg_top: two-wire register access, internal and
 * external clamp windows, channel selects.
 * assumes: sda pulled up; scl phases 10 mclk.
 */
`timescale 1ns/1ps
`include "lctg_regs.vh"
module line_clamp_timing_generator_tb_top;
reg mclk = 0, srst = 1, scl = 1, sda_m = 1, go = 0, pin_on = 0, pin_pol = 0;
wire sda_out, sda_oe, hsync, clamp_pin, clamp_active;
wire [2:0] clamp_midscale, clamp_ground;
wire sda_w = sda_m & ~(sda_oe & ~sda_out);
integer fail_count = 0, checked = 0, k, n, i;
reg [7:0] r0, r1, s, l;
initial
begin
    forever #10 mclk = ~mclk;
end
lctg_top u_dut (.mclk(mclk), .srst(srst), .scl(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .hsync(hsync),
    .clamp_pin(clamp_pin), .clamp_active(clamp_active),
    .clamp_midscale(clamp_midscale), .clamp_ground(clamp_ground));
lctg_video_src u_src (.mclk(mclk), .go(go), .pin_on(pin_on),
    .pin_pol(pin_pol), .hsync(hsync), .clamp_pin(clamp_pin));
// ----------------------------------------
// tasks
// ----------------------------------------
task tick(input integer c);
begin
    repeat (c) @(posedge mclk);
    #1;
end
endtask
task chk(input [15:0] got, input [15:0] exp);
begin
    checked = checked + 1;
    if (got !== exp)
    begin
        fail_count = fail_count + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
end
endtask
task conclude;
begin
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
end
endtask
task bitx(input b, output r);
begin
    sda_m = b;
    tick(5);
    scl = 1;
    tick(5);
    r = sda_w;
    tick(5);
    scl = 0;
    tick(5);
end
endtask
task start;
begin
    sda_m = 1;
    tick(5);
    scl = 1;
    tick(5);
    sda_m = 0;
    tick(5);
    scl = 0;
    tick(5);
end
endtask
task stop;
begin
    sda_m = 0;
    tick(5);
    scl = 1;
    tick(5);
    sda_m = 1;
    tick(5);
end
endtask
task tx(input [7:0] d, input ea);
    integer j;
    reg r;
begin
    for (j = 7; j >= 0; j = j - 1)
        bitx(d[j], r);
    bitx(1'b1, r);
    chk(r, !ea);
end
endtask
task rx(input last, output [7:0] d);
    integer j;
    reg r;
begin
    for (j = 7; j >= 0; j = j - 1)
        bitx(1'b1, d[j]);
    bitx(last, r);
end
endtask
task wr(input [7:0] ofs, input [7:0] d);
begin
    start;
    tx({`LCTG_DEV_ADDR, 1'b0}, 1);
    tx(ofs, 1);
    tx(d, 1);
    stop;
end
endtask
task rd(input [7:0] ofs, output [7:0] d0, output [7:0] d1);
begin
    start;
    tx({`LCTG_DEV_ADDR, 1'b0}, 1);
    tx(ofs, 1);
    start;
    tx({`LCTG_DEV_ADDR, 1'b1}, 1);
    rx(0, d0);
    rx(1, d1);
    stop;
end
endtask
task line(input [7:0] ds, input [7:0] dl, input [2:0] mid);
begin
    go = 1;
    tick(1);
    go = 0;
    n = 0;
    while (hsync !== 1'b0 && n < 50)
    begin
        tick(1);
        n = n + 1;
    end
    if (n == 50)
    begin
        fail_count = fail_count + 1;
        conclude;
    end
    k = 0;
    while (clamp_active !== 1'b1 && k < 280)
    begin
        tick(1);
        k = k + 1;
    end
    chk(k, dl == 0 ? 280 : ds + 2);
    chk({clamp_midscale, clamp_ground}, dl == 0 ? 0 : {mid, ~mid});
    n = 0;
    while (clamp_active === 1'b1 && n < 300)
    begin
        tick(1);
        n = n + 1;
    end
    chk(n, dl);
    tick(20);
    chk(clamp_active, 0);
end
endtask
task ext(input pol);
begin
    wr(`LCTG_OFS_CTRL, pol ? 8'h50 : 8'h10);
    pin_pol = pol;
    tick(3);
    chk(clamp_active, 0);
    pin_on = 1;
    tick(3);
    chk(clamp_active, 1);
    pin_on = 0;
    tick(3);
    chk(clamp_active, 0);
end
endtask
// ----------------------------------------
// sequence
// ----------------------------------------
initial
begin
    repeat (90000) @(posedge mclk);
    fail_count = fail_count + 1;
    conclude;
end
initial
begin
    tick(4);
    srst = 0;
    rd(`LCTG_OFS_CTRL, r0, r1);
    chk(r0, `LCTG_RST_CTRL);
    chk(r1, 8'h04);
    rd(`LCTG_OFS_START, r0, r1);
    chk(r1, 8'h28);
    rd(8'h30, r0, r1);
    chk({r0, r1}, 0);
    start;
    tx({`LCTG_DEV_ADDR ^ 7'h01, 1'b0}, 0);
    stop;
    line(8'h04, 8'h28, 3'h0);
    for (i = 0; i < 3; i = i + 1)
    begin
        {s, l} = i == 0 ? 16'hffff : i == 1 ? 16'h1001 : 16'h0700;
        wr(`LCTG_OFS_START, s);
        wr(`LCTG_OFS_LENGTH, l);
        wr(`LCTG_OFS_CTRL, i == 1 ? 8'h8a : 8'h00);
        rd(`LCTG_OFS_CTRL, r0, r1);
        chk({r0, r1}, {i == 1 ? 8'h8a : 8'h00, s});
        rd(`LCTG_OFS_LENGTH, r0, r1);
        chk(r0, l);
        line(s, l, i == 1 ? 3'h5 : 3'h0);
    end
    ext(1);
    ext(0);
    wr(`LCTG_OFS_CTRL, 8'h00);
    pin_pol = 0;
    pin_on = 1;
    tick(3);
    chk(clamp_active, 0);
    pin_on = 0;
    conclude;
end
endmodule // line_clamp_timing_generator_tb_top
